// [src/nfcb_pkg.sv]
// shared constants and types for the contactless type b front end
package nfcb_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned SUBCAR_HZ = 848_000;
    localparam int unsigned RATE_106_BPS = 106_000;
    localparam int unsigned RATE_212_BPS = 212_000;
    localparam int unsigned RATE_424_BPS = 424_000;
    localparam int unsigned SUBCAR_HALF = CLK_HZ / (2 * SUBCAR_HZ);
    localparam int unsigned ETU_106 = CLK_HZ / RATE_106_BPS;
    localparam int unsigned ETU_212 = CLK_HZ / RATE_212_BPS;
    localparam int unsigned ETU_424 = CLK_HZ / RATE_424_BPS;
    localparam int unsigned CHAR_BITS = 10;
    localparam int unsigned SOF_LOW_ETU = 10;
    localparam int unsigned SOF_HIGH_ETU = 2;
    localparam int unsigned EOF_LOW_ETU = 10;
    localparam int unsigned MAX_FIELD = 256;
    localparam int unsigned CRC_BYTES = 2;
    localparam int unsigned MIN_FIELD = 3;
    localparam logic [9:0] CC_BASE = 10'h3b0;
    localparam logic [15:0] CC_SIZE = 16'h0010;
    localparam logic [9:0] NLEN_BASE = 10'h00c;
    localparam logic [15:0] NLEN_SIZE = 16'h0002;
    localparam logic [9:0] MSG_BASE = 10'h010;
    localparam logic [15:0] MSG_LAST_OFF = 16'h03a1;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;
    localparam logic [7:0] CMD_REQB = 8'h05;
    localparam logic [7:0] AFI_ANY = 8'h00;
    typedef enum logic [1:0] {
        NFCB_SEL_NONE = 2'b00,
        NFCB_SEL_CC = 2'b01,
        NFCB_SEL_NDEF = 2'b10
    } nfcb_file_t;
    typedef enum logic [1:0] {
        NFCB_RATE_106 = 2'b00,
        NFCB_RATE_212 = 2'b01,
        NFCB_RATE_424 = 2'b10
    } nfcb_rate_t;
    typedef enum logic [1:0] {
        NFCB_EV_BYTE = 2'b00,
        NFCB_EV_EOF = 2'b01,
        NFCB_EV_ERR = 2'b10
    } nfcb_ev_t;
    typedef struct packed {
        nfcb_ev_t kind;
        logic [7:0] data;
    } nfcb_link_ev_t;
    typedef struct packed {
        logic ok;
        logic [9:0] addr;
    } nfcb_map_t;
endpackage

// [src/nfcb_frontend.sv]
// contactless type b framer, afi filter and ndef file address mapper
`timescale 1ns/1ps
// Functional notes
// - cc file offset zero maps to 0x03b0, block 59, offsets following linearly.
// - ndef length field maps to physical addresses 0x000c and 0x000d.
// - ndef offset 0x0002 maps to 0x0010, message bytes continue upward.
// - ndef length field is a fixed two-byte quantity at file head.
// - one access may span length field and message, bridging the gap.
// - character is start bit, eight data bits lsb first, stop bit.
// - bit rates 106, 212 and 424 kbps supported.
// - replies use load modulation of bpsk coded 848 khz subcarrier.
// - frame data field never exceeds 256 bytes.
// - every frame delimited by start-of-frame and end-of-frame markers.
// - no cid or nad in block prologue either way; rx rejects i-blocks with them, tx unchecked.
// - block field is pcb byte, information bytes, two-byte crc_b.
// - family identifier held in system memory, requests compared against it.
// - request afi 0x00 answered whatever the stored identifier.
// - afi 0xy0 answered only if upper nibble matches stored upper nibble.
// - afi 0x0y answered only if lower nibble matches stored lower nibble.
// - any other afi answered only on full eight-bit match.
// - cc file in block 59, ndef file in block zero part plus 1..58.
module nfcb_frontend (
    input wire logic clock,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic rx_bit,
    input wire nfcb_pkg::nfcb_rate_t rate_sel,
    input wire logic [7:0] stored_afi,
    input wire nfcb_pkg::nfcb_file_t file_sel,
    input wire logic [15:0] file_off,
    output nfcb_pkg::nfcb_map_t phys_map,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_frame_ok,
    output logic rx_frame_bad,
    output logic reqb_hit,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    output logic tx_busy,
    output logic tx_level,
    output logic load_mod
);
    import nfcb_pkg::*;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_SOF = 3'b001,
        RX_WAIT_HIGH = 3'b010,
        RX_GAP = 3'b011,
        RX_CHAR = 3'b100
    } nfcb_rx_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_SOF_LOW = 3'b001,
        TX_SOF_HIGH = 3'b010,
        TX_CHAR = 3'b011,
        TX_EOF = 3'b100
    } nfcb_tx_t;

    typedef enum logic [1:0] {
        SRC_DATA = 2'b00,
        SRC_CRC_LO = 2'b01,
        SRC_CRC_HI = 2'b10
    } nfcb_src_t;

    function automatic logic [15:0] crc_b_step(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    function automatic logic afi_match(input logic [7:0] req, input logic [7:0] own);
        if (req == AFI_ANY) begin
            return 1'b1;
        end else if (req[3:0] == 4'h0) begin
            return req[7:4] == own[7:4];
        end else if (req[7:4] == 4'h0) begin
            return req[3:0] == own[3:0];
        end else begin
            return req == own;
        end
    endfunction

    function automatic nfcb_map_t map_file(input nfcb_file_t sel, input logic [15:0] off);
        nfcb_map_t m;
        m = '{ok: 1'b0, addr: 10'h000};
        case (sel)
            NFCB_SEL_CC: begin
                m.ok = off < CC_SIZE;
                m.addr = CC_BASE + off[9:0];
            end
            NFCB_SEL_NDEF: begin
                if (off < NLEN_SIZE) begin
                    m.ok = 1'b1;
                    m.addr = NLEN_BASE + off[9:0];
                end else begin
                    m.ok = off <= MSG_LAST_OFF;
                    m.addr = MSG_BASE + (off[9:0] - NLEN_SIZE[9:0]);
                end
            end
            default: m = '{ok: 1'b0, addr: 10'h000};
        endcase
        return m;
    endfunction

    // address mapper, registered so consecutive offsets run across the gap
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phys_map <= '{ok: 1'b0, addr: 10'h000};
        end else begin
            phys_map <= map_file(file_sel, file_off);
        end
    end

    // link side receiver, one bit per link clock
    logic link_s1;
    logic link_s2;
    nfcb_rx_t rx_state;
    logic [3:0] rx_cnt;
    logic [7:0] rx_shift;
    nfcb_link_ev_t link_ev;
    logic link_tog;

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            link_s1 <= 1'b1;
            link_s2 <= 1'b1;
        end else begin
            link_s1 <= rx_bit;
            link_s2 <= link_s1;
        end
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            rx_state <= RX_IDLE;
            rx_cnt <= 4'h0;
            rx_shift <= 8'h00;
            link_ev <= '{kind: NFCB_EV_BYTE, data: 8'h00};
            link_tog <= 1'b0;
        end else begin
            case (rx_state)
                RX_IDLE: begin
                    rx_cnt <= 4'h1;
                    if (!link_s2) begin
                        rx_state <= RX_SOF;
                    end
                end
                RX_SOF: begin
                    if (link_s2) begin
                        rx_state <= RX_IDLE;
                    end else begin
                        rx_cnt <= rx_cnt + 4'h1;
                        if (rx_cnt == 4'(SOF_LOW_ETU - 1)) begin
                            rx_state <= RX_WAIT_HIGH;
                        end
                    end
                end
                RX_WAIT_HIGH: begin
                    if (link_s2) begin
                        rx_state <= RX_GAP;
                    end
                end
                RX_GAP: begin
                    rx_cnt <= 4'h0;
                    if (!link_s2) begin
                        rx_state <= RX_CHAR;
                    end
                end
                RX_CHAR: begin
                    rx_cnt <= rx_cnt + 4'h1;
                    if (rx_cnt < 4'(CHAR_BITS - 2)) begin
                        rx_shift <= {link_s2, rx_shift[7:1]};
                    end else begin
                        link_tog <= ~link_tog;
                        if (link_s2) begin
                            link_ev <= '{kind: NFCB_EV_BYTE, data: rx_shift};
                            rx_state <= RX_GAP;
                        end else begin
                            link_ev <= '{kind: (rx_shift == 8'h00) ? NFCB_EV_EOF : NFCB_EV_ERR, data: rx_shift};
                            rx_state <= RX_IDLE;
                        end
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // event crossing: data updated on the same link edge as the toggle and held stable for a whole character after it flips
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic ev_pulse;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end else begin
            tog_s1 <= link_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    assign ev_pulse = tog_s2 ^ tog_s3;

    // frame checker in the core domain
    logic [8:0] rx_count;
    logic [15:0] rx_crc;
    logic [7:0] rx_first;
    logic [7:0] rx_second;
    logic rx_over;
    logic frame_good;
    logic prologue_bad;

    assign prologue_bad = (rx_first[7:6] == 2'b00) && rx_first[1] && (rx_first[3] || rx_first[2]);
    assign frame_good = (rx_count >= 9'(MIN_FIELD)) && !rx_over && (rx_crc == CRC_RESIDUE) && !prologue_bad;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_count <= 9'h000;
            rx_crc <= CRC_INIT;
            rx_first <= 8'h00;
            rx_second <= 8'h00;
            rx_over <= 1'b0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            rx_frame_ok <= 1'b0;
            rx_frame_bad <= 1'b0;
            reqb_hit <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            rx_frame_ok <= 1'b0;
            rx_frame_bad <= 1'b0;
            reqb_hit <= 1'b0;
            if (ev_pulse) begin
                case (link_ev.kind)
                    NFCB_EV_BYTE: begin
                        if (rx_count == 9'(MAX_FIELD)) begin
                            rx_over <= 1'b1;
                        end else begin
                            rx_count <= rx_count + 9'h001;
                            rx_valid <= 1'b1;
                        end
                        rx_data <= link_ev.data;
                        rx_crc <= crc_b_step(rx_crc, link_ev.data);
                        if (rx_count == 9'h000) begin
                            rx_first <= link_ev.data;
                        end
                        if (rx_count == 9'h001) begin
                            rx_second <= link_ev.data;
                        end
                    end
                    NFCB_EV_EOF: begin
                        rx_frame_ok <= frame_good;
                        rx_frame_bad <= !frame_good;
                        reqb_hit <= frame_good && (rx_first == CMD_REQB) && afi_match(rx_second, stored_afi);
                        rx_count <= 9'h000;
                        rx_crc <= CRC_INIT;
                        rx_over <= 1'b0;
                    end
                    default: begin
                        rx_frame_bad <= 1'b1;
                        rx_count <= 9'h000;
                        rx_crc <= CRC_INIT;
                        rx_over <= 1'b0;
                    end
                endcase
            end
        end
    end

    // elementary time unit timer for the transmitter
    logic [11:0] etu_cnt;
    logic [11:0] etu_len;
    logic etu_tick;

    always_comb begin
        case (rate_sel)
            NFCB_RATE_212: etu_len = 12'(ETU_212 - 1);
            NFCB_RATE_424: etu_len = 12'(ETU_424 - 1);
            default: etu_len = 12'(ETU_106 - 1);
        endcase
    end

    assign etu_tick = (etu_cnt == 12'h000);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            etu_cnt <= 12'h000;
        end else if (etu_tick || !tx_busy) begin
            etu_cnt <= etu_len;
        end else begin
            etu_cnt <= etu_cnt - 12'h001;
        end
    end

    // transmit framer
    nfcb_tx_t tx_state;
    nfcb_src_t tx_src;
    logic [3:0] tx_bitn;
    logic [9:0] tx_shift;
    logic [15:0] tx_crc;
    logic [8:0] tx_count;
    logic tx_cur_last;
    logic char_end;
    logic take_data;
    logic [15:0] crc_out;

    assign tx_busy = (tx_state != TX_IDLE);
    assign char_end = (tx_state == TX_CHAR) && etu_tick && (tx_bitn == 4'(CHAR_BITS - 1));
    assign take_data = char_end && (tx_src == SRC_DATA) && !tx_cur_last;
    assign tx_ready = (tx_state == TX_IDLE) || take_data;
    assign crc_out = ~tx_crc;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_state <= TX_IDLE;
            tx_src <= SRC_DATA;
            tx_bitn <= 4'h0;
            tx_shift <= 10'h3ff;
            tx_crc <= CRC_INIT;
            tx_count <= 9'h000;
            tx_cur_last <= 1'b0;
            tx_level <= 1'b1;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    tx_level <= 1'b1;
                    tx_bitn <= 4'h0;
                    tx_src <= SRC_DATA;
                    if (tx_valid) begin
                        tx_shift <= {1'b1, tx_data, 1'b0};
                        tx_crc <= crc_b_step(CRC_INIT, tx_data);
                        tx_count <= 9'h001;
                        tx_cur_last <= tx_last;
                        tx_level <= 1'b0;
                        tx_state <= TX_SOF_LOW;
                    end
                end
                TX_SOF_LOW: begin
                    if (etu_tick) begin
                        tx_bitn <= tx_bitn + 4'h1;
                        if (tx_bitn == 4'(SOF_LOW_ETU - 1)) begin
                            tx_bitn <= 4'h0;
                            tx_level <= 1'b1;
                            tx_state <= TX_SOF_HIGH;
                        end
                    end
                end
                TX_SOF_HIGH: begin
                    if (etu_tick) begin
                        tx_bitn <= tx_bitn + 4'h1;
                        if (tx_bitn == 4'(SOF_HIGH_ETU - 1)) begin
                            tx_bitn <= 4'h0;
                            tx_level <= tx_shift[0];
                            tx_state <= TX_CHAR;
                        end
                    end
                end
                TX_CHAR: begin
                    if (etu_tick && tx_bitn != 4'(CHAR_BITS - 1)) begin
                        tx_bitn <= tx_bitn + 4'h1;
                        tx_level <= tx_shift[tx_bitn + 4'h1];
                    end else if (char_end) begin
                        if (tx_src == SRC_DATA && !tx_cur_last) begin
                            if (tx_valid) begin
                                tx_shift <= {1'b1, tx_data, 1'b0};
                                tx_crc <= crc_b_step(tx_crc, tx_data);
                                tx_count <= tx_count + 9'h001;
                                tx_cur_last <= tx_last || (tx_count == 9'(MAX_FIELD - CRC_BYTES - 1));
                                tx_bitn <= 4'h0;
                                tx_level <= 1'b0;
                            end
                        end else if (tx_src == SRC_DATA) begin
                            tx_shift <= {1'b1, crc_out[7:0], 1'b0};
                            tx_src <= SRC_CRC_LO;
                            tx_bitn <= 4'h0;
                            tx_level <= 1'b0;
                        end else if (tx_src == SRC_CRC_LO) begin
                            tx_shift <= {1'b1, crc_out[15:8], 1'b0};
                            tx_src <= SRC_CRC_HI;
                            tx_bitn <= 4'h0;
                            tx_level <= 1'b0;
                        end else begin
                            tx_bitn <= 4'h0;
                            tx_level <= 1'b0;
                            tx_state <= TX_EOF;
                        end
                    end
                end
                TX_EOF: begin
                    if (etu_tick) begin
                        tx_bitn <= tx_bitn + 4'h1;
                        if (tx_bitn == 4'(EOF_LOW_ETU - 1)) begin
                            tx_level <= 1'b1;
                            tx_state <= TX_IDLE;
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // subcarrier and bpsk load modulation
    logic [7:0] sub_cnt;
    logic subcar;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sub_cnt <= 8'h00;
            subcar <= 1'b0;
        end else if (sub_cnt == 8'(SUBCAR_HALF - 1)) begin
            sub_cnt <= 8'h00;
            subcar <= ~subcar;
        end else begin
            sub_cnt <= sub_cnt + 8'h01;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            load_mod <= 1'b0;
        end else begin
            load_mod <= tx_busy && (subcar ^ tx_level);
        end
    end
endmodule // nfcb_frontend

// [tb/nfcb_frontend_asserts.sv]
// assertion checker for the type b front end ports
`timescale 1ns/1ps
module nfcb_frontend_asserts (
    input wire logic clock,
    input wire logic rst,
    input wire nfcb_pkg::nfcb_file_t file_sel,
    input wire logic [15:0] file_off,
    input wire nfcb_pkg::nfcb_map_t phys_map,
    input wire logic rx_valid,
    input wire logic rx_frame_ok,
    input wire logic rx_frame_bad,
    input wire logic reqb_hit,
    input wire logic tx_busy,
    input wire logic tx_level,
    input wire logic load_mod
);
    import nfcb_pkg::*;
    localparam int unsigned LM_GAP = 2 * SUBCAR_HALF + 2;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    logic [8:0] rx_cnt;
    logic [8:0] still;
    logic lm_prev;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_cnt <= 9'h000;
        end else if (rx_frame_ok || rx_frame_bad) begin
            rx_cnt <= 9'h000;
        end else if (rx_valid) begin
            rx_cnt <= rx_cnt + 9'h001;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            still <= 9'h000;
            lm_prev <= 1'b0;
        end else begin
            lm_prev <= load_mod;
            still <= (!tx_busy || load_mod != lm_prev) ? 9'h000 : still + 9'h001;
        end
    end
    a_cc_map: assert property (
        file_sel == NFCB_SEL_CC && file_off < CC_SIZE |=>
        phys_map.ok && phys_map.addr == CC_BASE + $past(file_off[9:0])) else $error("cc map wrong");
    a_nlen_map: assert property (
        file_sel == NFCB_SEL_NDEF && file_off < NLEN_SIZE |=>
        phys_map.ok && phys_map.addr == NLEN_BASE + $past(file_off[9:0])) else $error("length map wrong");
    a_msg_map: assert property (
        file_sel == NFCB_SEL_NDEF && file_off >= NLEN_SIZE && file_off <= MSG_LAST_OFF |=>
        phys_map.ok && phys_map.addr == MSG_BASE + $past(file_off[9:0]) - 10'h002) else $error("msg map wrong");
    a_map_refuse: assert property (
        file_sel == NFCB_SEL_NONE || (file_sel == NFCB_SEL_CC && file_off >= CC_SIZE) ||
        (file_sel == NFCB_SEL_NDEF && file_off > MSG_LAST_OFF) |=> !phys_map.ok) else $error("map not refused");
    a_hit_ok: assert property (
        reqb_hit |-> rx_frame_ok) else $error("hit without good frame");
    a_frame_excl: assert property (
        rx_frame_bad |-> !rx_frame_ok) else $error("frame both good and bad");
    a_rx_limit: assert property (
        rx_cnt <= 9'h100) else $error("more than 256 bytes delivered");
    a_idle_quiet: assert property (
        !tx_busy [*2] |-> !load_mod && tx_level) else $error("link not idle");
    a_sub_toggle: assert property (
        still <= LM_GAP) else $error("subcarrier stopped");
    c_hit: cover property (reqb_hit);
    c_bad: cover property (rx_frame_bad);
    c_tx: cover property ($rose(tx_busy));
endmodule // nfcb_frontend_asserts

// [tb/nfcb_reader_model.sv]
// behavioural reader that sends type b frames on the link
`timescale 1ns/1ps
module nfcb_reader_model (
    input wire logic lraw,
    output logic lk_en,
    output logic rx_bit
);
    import nfcb_pkg::*;
    initial begin
        lk_en = 1'b0;
        rx_bit = 1'b1;
    end
    task automatic put(input logic v, input int n);
        repeat (n) begin
            @(negedge lraw);
            lk_en <= 1'b1;
            rx_bit <= v;
        end
    endtask
    task automatic send(input logic [7:0] b[$]);
        if (b.size() > MAX_FIELD) b = b[0:MAX_FIELD-1];
        put(1'b1, 3);
        put(1'b0, 11);
        put(1'b1, 2);
        foreach (b[i]) begin
            put(1'b0, 1);
            for (int k = 0; k < 8; k++) put(b[i][k], 1);
            put(1'b1, 1);
        end
        put(1'b0, 10);
        put(1'b1, 5);
        @(negedge lraw);
        lk_en <= 1'b0;
    endtask
endmodule // nfcb_reader_model

// [tb/test_nfcb_frontend.sv]
// self-checking bench for the type b front end
`timescale 1ns/1ps
module test_nfcb_frontend;
    import nfcb_pkg::*;
    logic clock = 1'b0, rst = 1'b1, lraw = 1'b0, lk_en, link_clk, rx_bit, tx_valid = 1'b0, tx_last = 1'b0;
    nfcb_rate_t rate_sel = NFCB_RATE_106;
    nfcb_file_t file_sel = NFCB_SEL_NONE;
    logic [7:0] stored_afi = 8'h00, tx_data = 8'h00, rx_data;
    logic [15:0] file_off = 16'h0000;
    logic [31:0] seed = 32'hdfb6;
    nfcb_map_t phys_map;
    logic rx_valid, rx_frame_ok, rx_frame_bad, reqb_hit, tx_ready, tx_busy, tx_level, load_mod;
    int errors = 0, cmp_count = 0;
    logic [9:0] rxq[$];
    logic [7:0] txq[$];
    int etuq[$];
    logic [16:0] afi_tbl[8] = '{{8'h35, 8'h00, 1'b1}, {8'h35, 8'h30, 1'b1}, {8'h45, 8'h30, 1'b0},
        {8'h35, 8'h05, 1'b1}, {8'h36, 8'h05, 1'b0}, {8'h35, 8'h35, 1'b1}, {8'h36, 8'h35, 1'b0}, {8'h00, 8'h00, 1'b1}};
    always #2.5 clock = ~clock;
    initial #37 forever #80 lraw = ~lraw;
    assign link_clk = lraw & lk_en;
    nfcb_frontend dut_u (.clock(clock), .rst(rst), .link_clk(link_clk), .rx_bit(rx_bit), .rate_sel(rate_sel),
        .stored_afi(stored_afi), .file_sel(file_sel), .file_off(file_off), .phys_map(phys_map), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_frame_ok(rx_frame_ok), .rx_frame_bad(rx_frame_bad), .reqb_hit(reqb_hit),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .tx_busy(tx_busy),
        .tx_level(tx_level), .load_mod(load_mod));
    nfcb_reader_model rdr_u (.lraw(lraw), .lk_en(lk_en), .rx_bit(rx_bit));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] crc_b(input logic [7:0] q[$]);
        logic [15:0] c;
        c = CRC_INIT;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        return ~c;
    endfunction
    task automatic check(input bit ok, input string m);
        cmp_count++;
        if (!ok) begin
            errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic close_out();
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clock) if (!rst) begin
        seed <= lfsr(seed);
        file_sel <= (seed[1:0] == 2'b11) ? NFCB_SEL_NDEF : nfcb_file_t'(seed[1:0]);
        file_off <= seed[2] ? {6'h00, seed[12:3]} : {11'h000, seed[7:3]};
    end else file_sel <= NFCB_SEL_NONE;
    task automatic note(input logic [9:0] got);
        logic [9:0] exp;
        exp = rxq.size() > 0 ? rxq.pop_front() : 10'h3ff;
        check(got === exp, "rx event mismatch");
    endtask
    always @(posedge clock) begin
        if (rx_valid === 1'b1) note({2'b00, rx_data});
        if (rx_frame_ok === 1'b1) note({2'b01, 7'h00, reqb_hit});
        if (rx_frame_bad === 1'b1) note(10'h200);
    end
    task automatic rx_frame(input logic [7:0] q[$], input logic [1:0] kind, input logic hit, input logic [7:0] flip);
        logic [15:0] c;
        int n;
        c = crc_b(q);
        q.push_back(c[7:0]);
        q.push_back(c[15:8] ^ flip);
        foreach (q[i]) rxq.push_back({2'b00, q[i]});
        rxq.push_back({kind, 7'h00, hit});
        rdr_u.send(q);
        n = 0;
        while (rxq.size() > 0 && n < 400) begin
            @(posedge clock);
            n++;
        end
        check(rxq.size() == 0, "rx frame incomplete");
    endtask
    task automatic span(input logic lvl, output int n);
        n = 0;
        while (tx_level === lvl && n < 20000) begin
            @(posedge clock);
            n++;
        end
    endtask
    task automatic rd_char(input int e, output logic [9:0] ch);
        repeat (e / 2) @(posedge clock);
        for (int b = 0; b < 10; b++) begin
            ch[b] = tx_level;
            if (b < 9) repeat (e) @(posedge clock);
        end
    endtask
    task automatic tx_send(input nfcb_rate_t r, input int e, input logic [7:0] b, input bit full);
        logic [7:0] q[$];
        logic [15:0] c;
        q.push_back(b);
        c = crc_b(q);
        if (full) txq = '{b, c[7:0], c[15:8]};
        etuq.push_back(e);
        rate_sel <= r;
        @(posedge clock);
        tx_data <= b;
        tx_last <= 1'b1;
        tx_valid <= 1'b1;
        @(posedge clock iff tx_ready === 1'b1);
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
    endtask
    initial begin : tx_watch
        int e, n;
        logic [9:0] ch;
        forever begin
            @(posedge clock iff (tx_busy === 1'b1 && tx_level === 1'b0));
            e = etuq.size() > 0 ? etuq.pop_front() : 1;
            span(1'b0, n);
            check(n >= 10 * e - 2 && n <= 10 * e + 2, "sof low span");
            if (txq.size() > 0) begin
                span(1'b1, n);
                check(n >= 2 * e - 2 && n <= 2 * e + 2, "sof high span");
                while (txq.size() > 0) begin
                    rd_char(e, ch);
                    check(ch === {1'b1, txq.pop_front(), 1'b0}, "tx char");
                    span(1'b1, n);
                end
                rd_char(e, ch);
                check(ch === 10'h000, "tx end marker");
                span(1'b0, n);
                repeat (2) @(posedge clock);
                check(tx_busy === 1'b0 && tx_level === 1'b1, "tx not idle");
            end
        end
    end
    initial begin
        #500000;
        errors++;
        close_out();
    end
    initial begin
        logic [7:0] q[$];
        int n;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        foreach (afi_tbl[i]) begin
            @(posedge clock);
            stored_afi <= afi_tbl[i][16:9];
            q = '{CMD_REQB, afi_tbl[i][8:1], 8'h00};
            rx_frame(q, 2'b01, afi_tbl[i][0], 8'h00);
        end
        q = '{8'h02, seed[7:0]};
        rx_frame(q, 2'b01, 1'b0, 8'h00);
        q = '{8'h0a, seed[7:0]};
        rx_frame(q, 2'b10, 1'b0, 8'h00);
        q = '{CMD_REQB, 8'h00, 8'h00};
        rx_frame(q, 2'b10, 1'b0, 8'h5a);
        for (int r = 0; r < 2; r++) begin
            tx_send(nfcb_rate_t'(r), r == 0 ? ETU_106 : ETU_212, 8'h02, 1'b0);
            repeat ((r == 0 ? ETU_106 : ETU_212) * 11) @(posedge clock);
            rst <= 1'b1;
            repeat (5) @(posedge clock);
            rst <= 1'b0;
        end
        tx_send(NFCB_RATE_424, ETU_424, seed[7:0], 1'b1);
        n = 0;
        while ((txq.size() > 0 || tx_busy !== 1'b0) && n < 40000) begin
            @(posedge clock);
            n++;
        end
        repeat (10) @(posedge clock);
        check(txq.size() == 0 && tx_busy === 1'b0, "tx frame incomplete");
        close_out();
    end
endmodule // test_nfcb_frontend
bind nfcb_frontend nfcb_frontend_asserts chk_u (.clock(clock), .rst(rst), .file_sel(file_sel), .file_off(file_off),
    .phys_map(phys_map), .rx_valid(rx_valid), .rx_frame_ok(rx_frame_ok), .rx_frame_bad(rx_frame_bad),
    .reqb_hit(reqb_hit), .tx_busy(tx_busy), .tx_level(tx_level), .load_mod(load_mod));
